// [rtl/utopia_in_ctrl.sv]
// What this block does
// - enable bit n recognises link n address
// - parity sense 0 odd, 1 even
// - loopback returns transmit cells via receive
// - width bit 0 sixteen, 1 eight bits
// - controller reset bit holds controller reset
// - unassigned filter drops cells, counts them
// - idle filter drops cells, counts them
// - unassigned: three zero bytes, 0000xxx0
// - idle: three zero bytes, 00000001
// - coset disable bit removes coset
// - mode 11 corrects single, drops multi
// - mode 10 drops errored, no correction
// - mode 01 corrects single, never drops
// - mode 00 skips verification entirely
// - sticky rollover flag, cleared writing zero
// - sticky first-error flag, cleared writing zero
// - writing transfer bit snapshots error count
// - transfer bit reads one when done
// - counter reset bit holds counter cleared
// - low bits show snapshot, not live
// - top three control bits read zero
// - address registers pair link N, N+8
`timescale 1ns/1ps
`default_nettype none

module utopia_in_ctrl (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        resetn,
    // microprocessor port
    input  wire logic                        cpu_cs,
    input  wire logic                        cpu_wr,
    input  wire logic                        cpu_rd,
    input  wire logic [7:0]                  cpu_addr,
    input  wire logic [15:0]                 cpu_wdata,
    output logic      [15:0]                 cpu_rdata,
    // utopia input side from the atm layer
    input  wire logic                        u_clk,
    input  wire logic [15:0]                 u_data,
    input  wire logic                        u_prty,
    input  wire logic                        u_soc,
    input  wire logic                        u_enb_n,
    input  wire logic [4:0]                  u_addr,
    // cell verdicts
    output utopia_in_pkg::cell_result_t      cell_out,
    output logic                             cell_valid,
    output logic                             parity_err,
    output logic      [15:0]                 idle_unasg_count,
    // receive side routing
    output logic                             loopback_en,
    output logic                             rx_width8
);
    import utopia_in_pkg::*;

    // register state
    logic [15:0]           link_en_r;
    logic [15:0]           ctrl_r;
    logic [15:0]           addr_r [NUM_ADDR_REG];
    logic                  roll_r;
    logic                  seen_r;
    logic                  xfer_done_r;
    logic                  xfer_pend_r;
    logic                  cnt_rst_r;
    logic [PERR_CNT_W-1:0] snap_r;
    logic [PERR_CNT_W-1:0] perr_cnt_r;

    logic wr_stb;
    logic rd_stb;
    assign wr_stb = cpu_cs && cpu_wr;
    assign rd_stb = cpu_cs && cpu_rd;

    hec_mode_t hec_mode;
    assign hec_mode = hec_mode_t'(ctrl_r[CTRL_HEC_HI:CTRL_HEC_LO]);

    // register writes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            link_en_r <= RST_LINK_EN;
        end else if (wr_stb && cpu_addr == OFF_LINK_EN) begin
            link_en_r <= cpu_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= RST_CTRL;
        end else if (wr_stb && cpu_addr == OFF_CTRL) begin
            ctrl_r <= cpu_wdata & CTRL_RW_MASK;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_ADDR_REG; gi++) begin : g_addr
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    addr_r[gi] <= RST_ADDR;
                end else if (wr_stb && cpu_addr == OFF_ADDR_BASE + 8'(gi)) begin
                    addr_r[gi] <= '0;
                    addr_r[gi][ADDR_HI_LSB +: ADDR_W] <= cpu_wdata[ADDR_HI_LSB +: ADDR_W];
                    addr_r[gi][ADDR_W-1:0]            <= cpu_wdata[ADDR_W-1:0];
                end
            end
        end
    endgenerate

    logic perr_wr;
    assign perr_wr = wr_stb && cpu_addr == OFF_PERR;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_rst_r <= 1'b0;
        end else if (perr_wr) begin
            cnt_rst_r <= cpu_wdata[PERR_CNT_RST];
        end
    end

    // register reads
    logic [15:0] rd_val;
    always_comb begin
        rd_val = '0;
        if (cpu_addr >= OFF_ADDR_BASE && cpu_addr <= OFF_ADDR_LAST) begin
            rd_val = addr_r[cpu_addr[2:0]];
        end else if (cpu_addr == OFF_LINK_EN) begin
            rd_val = link_en_r;
        end else if (cpu_addr == OFF_CTRL) begin
            rd_val = ctrl_r;
        end else if (cpu_addr == OFF_PERR) begin
            rd_val = {roll_r, seen_r, xfer_done_r, cnt_rst_r, snap_r};
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_rdata <= '0;
        end else if (rd_stb) begin
            cpu_rdata <= rd_val;
        end
    end

    // link pin synchronisers
    // all pins share one two-stage delay, so their relative timing is kept
    localparam int SYNC_W = 16 + 1 + 1 + 1 + 5 + 1;
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic              uclk_d_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {u_clk, u_data, u_prty, u_soc, u_enb_n, u_addr};
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            uclk_d_r <= 1'b0;
        end else begin
            uclk_d_r <= sync2_r[SYNC_W-1];
        end
    end

    logic        s_clk;
    logic [15:0] s_data;
    logic        s_prty;
    logic        s_soc;
    logic        s_enb_n;
    logic [4:0]  s_addr;
    assign {s_clk, s_data, s_prty, s_soc, s_enb_n, s_addr} = sync2_r;

    logic u_edge;
    assign u_edge = s_clk && !uclk_d_r;

    // address recognition
    logic       hit;
    logic [3:0] hit_link;
    always_comb begin
        hit      = 1'b0;
        hit_link = '0;
        for (int i = 0; i < NUM_LINKS; i++) begin
            if (!hit && link_en_r[i] &&
                addr_r[i % NUM_ADDR_REG][(i / NUM_ADDR_REG) * ADDR_HI_LSB +: ADDR_W] == s_addr) begin
                hit      = 1'b1;
                hit_link = 4'(i);
            end
        end
    end

    // selection is latched on edges with the enable idle, as in multi-phy polling
    logic       sel_ok_r;
    logic [3:0] sel_link_r;
    logic       ctl_reset;
    assign ctl_reset = ctrl_r[CTRL_CTL_RESET];

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sel_ok_r   <= 1'b0;
            sel_link_r <= '0;
        end else if (ctl_reset) begin
            sel_ok_r   <= 1'b0;
        end else if (u_edge && s_enb_n) begin
            sel_ok_r   <= hit;
            sel_link_r <= hit_link;
        end
    end

    logic xfer;
    assign xfer = u_edge && !s_enb_n && sel_ok_r && !ctl_reset;

    // parity
    logic par_calc;
    always_comb begin
        if (ctrl_r[CTRL_WIDTH8]) begin
            par_calc = ^{s_data[7:0], s_prty};
        end else begin
            par_calc = ^{s_data, s_prty};
        end
    end

    // odd sense wants an odd total; even sense an even total
    logic par_bad;
    assign par_bad = xfer && (par_calc == ctrl_r[CTRL_PAR_EVEN]);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            parity_err <= 1'b0;
        end else begin
            parity_err <= par_bad;
        end
    end

    logic cnt_wrap;
    assign cnt_wrap = par_bad && !cnt_rst_r && (&perr_cnt_r);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            perr_cnt_r <= RST_COUNT;
        end else if (cnt_rst_r) begin
            perr_cnt_r <= RST_COUNT;
        end else if (par_bad) begin
            perr_cnt_r <= perr_cnt_r + 12'h001;
        end
    end

    // sticky flags: a set in the same cycle as a clearing write wins
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            roll_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            if (cnt_wrap) begin
                roll_r <= 1'b1;
            end else if (perr_wr && !cpu_wdata[PERR_ROLLOVER]) begin
                roll_r <= 1'b0;
            end
            if (par_bad) begin
                seen_r <= 1'b1;
            end else if (perr_wr && !cpu_wdata[PERR_SEEN]) begin
                seen_r <= 1'b0;
            end
        end
    end

    // snapshot: request taken on the write, copy one cycle later
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            xfer_pend_r <= 1'b0;
            xfer_done_r <= 1'b0;
            snap_r      <= RST_COUNT;
        end else if (perr_wr && cpu_wdata[PERR_XFER]) begin
            xfer_pend_r <= 1'b1;
            xfer_done_r <= 1'b0;
        end else if (xfer_pend_r) begin
            xfer_pend_r <= 1'b0;
            xfer_done_r <= 1'b1;
            snap_r      <= perr_cnt_r;
        end
    end

    // header capture
    typedef enum logic [1:0] {ST_WAIT, ST_HDR, ST_PAYLOAD} hdr_state_t;
    hdr_state_t      st_r;
    logic [39:0]     hdr_r;
    logic [2:0]      nbytes_r;
    logic [3:0]      cell_link_r;
    logic            hdr_full_r;

    logic [2:0]  nb_base;
    logic [39:0] hdr_nxt;
    logic [2:0]  nb_nxt;
    always_comb begin
        nb_base = (s_soc || st_r == ST_WAIT) ? 3'd0 : nbytes_r;
        hdr_nxt = (s_soc || st_r == ST_WAIT) ? 40'h00_0000_0000 : hdr_r;
        nb_nxt  = nb_base;
        if (ctrl_r[CTRL_WIDTH8]) begin
            hdr_nxt = {hdr_nxt[31:0], s_data[7:0]};
            nb_nxt  = nb_base + 3'd1;
        end else if (nb_base == 3'd4) begin
            // third word: hec in the upper byte, user byte dropped
            hdr_nxt = {hdr_nxt[31:0], s_data[15:8]};
            nb_nxt  = 3'd5;
        end else begin
            hdr_nxt = {hdr_nxt[23:0], s_data};
            nb_nxt  = nb_base + 3'd2;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r        <= ST_WAIT;
            hdr_r       <= '0;
            nbytes_r    <= '0;
            cell_link_r <= '0;
            hdr_full_r  <= 1'b0;
        end else if (ctl_reset) begin
            st_r       <= ST_WAIT;
            nbytes_r   <= '0;
            hdr_full_r <= 1'b0;
        end else begin
            hdr_full_r <= 1'b0;
            if (xfer && (s_soc || st_r == ST_HDR)) begin
                hdr_r    <= hdr_nxt;
                nbytes_r <= nb_nxt;
                if (s_soc) begin
                    cell_link_r <= sel_link_r;
                end
                if (nb_nxt == 3'(HDR_BYTES)) begin
                    st_r       <= ST_PAYLOAD;
                    hdr_full_r <= 1'b1;
                end else begin
                    st_r <= ST_HDR;
                end
            end
        end
    end

    // header check
    function automatic logic [7:0] crc8(input logic [31:0] d);
        logic [7:0] c;
        c = '0;
        for (int b = 31; b >= 0; b--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[b]) ? HEC_POLY : 8'h00);
        end
        return c;
    endfunction

    // syndrome of a lone error in bit i of the 40-bit header
    function automatic logic [7:0] single_syn(input int i);
        logic [31:0] v;
        v = '0;
        if (i < 8) begin
            return 8'(1 << i);
        end
        v[i-8] = 1'b1;
        return crc8(v);
    endfunction

    logic [7:0]  expect_hec;
    logic [7:0]  syndrome;
    logic        one_bit;
    logic [39:0] flip;
    always_comb begin
        expect_hec = crc8(hdr_r[39:8]) ^ (ctrl_r[CTRL_COSET_OFF] ? 8'h00 : HEC_COSET);
        syndrome   = expect_hec ^ hdr_r[7:0];
        one_bit    = 1'b0;
        flip       = '0;
        for (int i = 0; i < 40; i++) begin
            if (syndrome == single_syn(i)) begin
                one_bit = 1'b1;
                flip[i] = 1'b1;
            end
        end
    end

    logic        hec_bad;
    logic        do_fix;
    logic        hec_drop;
    logic [39:0] fixed_hdr;
    always_comb begin
        hec_bad = (syndrome != 8'h00);
        do_fix  = 1'b0;
        hec_drop = 1'b0;
        unique case (hec_mode)
            HEC_OFF: begin
                do_fix   = 1'b0;
                hec_drop = 1'b0;
            end
            HEC_CORRECT: begin
                do_fix   = hec_bad && one_bit;
                hec_drop = 1'b0;
            end
            HEC_DISCARD: begin
                do_fix   = 1'b0;
                hec_drop = hec_bad;
            end
            HEC_BOTH: begin
                do_fix   = hec_bad && one_bit;
                hec_drop = hec_bad && !one_bit;
            end
        endcase
        fixed_hdr = do_fix ? (hdr_r ^ flip) : hdr_r;
    end

    // classification after any correction
    logic is_idle;
    logic is_unasg;
    logic filt_drop;
    assign is_idle   = fixed_hdr[39:16] == 24'h000000 && fixed_hdr[15:8] == 8'h01;
    assign is_unasg  = fixed_hdr[39:16] == 24'h000000 &&
                       fixed_hdr[15:12] == 4'h0 && !fixed_hdr[8];
    assign filt_drop = (is_idle && ctrl_r[CTRL_IDLE_FILT]) ||
                       (is_unasg && ctrl_r[CTRL_UNASG_FILT]);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cell_valid <= 1'b0;
            cell_out   <= '0;
        end else begin
            cell_valid <= hdr_full_r;
            if (hdr_full_r) begin
                cell_out.link       <= cell_link_r;
                cell_out.header     <= fixed_hdr[39:8];
                cell_out.hec        <= fixed_hdr[7:0];
                cell_out.drop       <= hec_drop || filt_drop;
                cell_out.corrected  <= do_fix;
                cell_out.idle_unasg <= filt_drop;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            idle_unasg_count <= '0;
        end else if (hdr_full_r && filt_drop) begin
            idle_unasg_count <= idle_unasg_count + 16'h0001;
        end
    end

    // receive side takes its cells from the transmit utopia while set
    assign loopback_en = ctrl_r[CTRL_LOOPBACK];
    assign rx_width8   = ctrl_r[CTRL_WIDTH8];

endmodule // utopia_in_ctrl

`default_nettype wire

// [rtl/utopia_in_pkg.sv]
package utopia_in_pkg;

    // register offsets on the microprocessor port (word addresses)
    localparam logic [7:0] OFF_ADDR_BASE  = 8'h40;
    localparam logic [7:0] OFF_ADDR_LAST  = 8'h47;
    localparam logic [7:0] OFF_LINK_EN    = 8'h50;
    localparam logic [7:0] OFF_CTRL       = 8'h52;
    localparam logic [7:0] OFF_PERR       = 8'h53;

    // reset values
    localparam logic [15:0] RST_LINK_EN   = 16'h0000;
    localparam logic [15:0] RST_CTRL      = 16'h0000;
    localparam logic [15:0] RST_ADDR      = 16'h0000;
    localparam logic [11:0] RST_COUNT     = 12'h000;

    // control register fields
    localparam int CTRL_PAR_EVEN   = 12;
    localparam int CTRL_LOOPBACK   = 9;
    localparam int CTRL_WIDTH8     = 7;
    localparam int CTRL_CTL_RESET  = 6;
    localparam int CTRL_UNASG_FILT = 4;
    localparam int CTRL_IDLE_FILT  = 3;
    localparam int CTRL_COSET_OFF  = 2;
    localparam int CTRL_HEC_HI     = 1;
    localparam int CTRL_HEC_LO     = 0;
    // writable bits of the control register; 15:13 read as zero
    localparam logic [15:0] CTRL_RW_MASK = 16'h1FFF;

    // parity error status register fields
    localparam int PERR_ROLLOVER = 15;
    localparam int PERR_SEEN     = 14;
    localparam int PERR_XFER     = 13;
    localparam int PERR_CNT_RST  = 12;
    localparam int PERR_CNT_W    = 12;

    // address register fields
    localparam int ADDR_W       = 5;
    localparam int ADDR_HI_LSB  = 8;
    localparam int NUM_LINKS    = 16;
    localparam int NUM_ADDR_REG = 8;

    // header check
    localparam logic [7:0] HEC_POLY  = 8'h07;
    localparam logic [7:0] HEC_COSET = 8'h55;
    localparam int HDR_BYTES = 5;

    typedef enum logic [1:0] {
        HEC_OFF     = 2'b00,
        HEC_CORRECT = 2'b01,
        HEC_DISCARD = 2'b10,
        HEC_BOTH    = 2'b11
    } hec_mode_t;

    // one accepted cell header and its verdict
    typedef struct packed {
        logic [3:0]  link;
        logic [31:0] header;
        logic [7:0]  hec;
        logic        drop;
        logic        corrected;
        logic        idle_unasg;
    } cell_result_t;

endpackage

// [testbench/atm_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module atm_master_model (
    // utopia input bus toward the device
    output logic        u_clk,
    output logic [15:0] u_data,
    output logic        u_prty,
    output logic        u_soc,
    output logic        u_enb_n,
    output logic [4:0]  u_addr
);
    initial begin
        u_clk = 1'b0;
        u_data = 16'h0000;
        u_prty = 1'b0;
        u_soc = 1'b0;
        u_enb_n = 1'b1;
        u_addr = 5'h1F;
    end
    // clock runs only inside a frame: one select edge, then the header beats
    task automatic send(input logic [4:0] a, input logic [39:0] h, input logic w8,
                        input logic even, input logic bad);
        logic [47:0] hp;
        logic [15:0] d;
        hp = {h, 8'h6A};
        u_addr = a;
        u_enb_n = 1'b1;
        #80 u_clk = 1'b1;
        #80 u_clk = 1'b0;
        for (int i = 0; i < (w8 ? 5 : 3); i++) begin
            d = w8 ? {~hp[47-8*i -: 8], hp[47-8*i -: 8]} : hp[47-16*i -: 16];
            u_data = d;
            u_soc = (i == 0);
            u_enb_n = 1'b0;
            u_addr = ~a;
            u_prty = ^(w8 ? d[7:0] : d) ^ ~even ^ bad;
            #80 u_clk = 1'b1;
            #80 u_clk = 1'b0;
        end
        // released bus shows inverted data so stale values cannot match
        u_enb_n = 1'b1;
        u_soc = 1'b0;
        u_data = ~d;
    endtask
endmodule // atm_master_model
`default_nettype wire

// [testbench/utopia_in_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, w) begin checks++; if ((g) !== (w)) begin mismatches++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, w); end end
module utopia_in_ctrl_bench;
    import utopia_in_pkg::*;
    typedef struct packed {
        logic [15:0] ctl;
        logic [31:0] hdr;
        logic [39:0] flip;
        logic        drop;
        logic        corr;
    } row_t;
    localparam logic [31:0] USR = 32'h12345678;
    row_t rows [13] = '{
        '{16'h0000, USR, 40'h100, 1'b0, 1'b0},
        '{16'h0001, USR, 40'h100, 1'b0, 1'b1},
        '{16'h0001, USR, 40'h300, 1'b0, 1'b0},
        '{16'h0002, USR, 40'h100, 1'b1, 1'b0},
        '{16'h0003, USR, 40'h001, 1'b0, 1'b1},
        '{16'h0003, USR, 40'h300, 1'b1, 1'b0},
        '{16'h0006, USR, 40'h000, 1'b0, 1'b0},
        '{16'h0002, USR, 40'h055, 1'b1, 1'b0},
        '{16'h1083, USR, 40'h100, 1'b0, 1'b1},
        '{16'h0008, 32'h1, 40'h0, 1'b1, 1'b0},
        '{16'h0010, 32'hE, 40'h0, 1'b1, 1'b0},
        '{16'h0010, 32'h1, 40'h0, 1'b0, 1'b0},
        '{16'h0008, 32'h2, 40'h0, 1'b0, 1'b0}
    };
    logic         core_clk, resetn, cpu_cs, cpu_wr, cpu_rd, fdrop, seen;
    logic [7:0]   cpu_addr;
    logic [15:0]  cpu_wdata, cpu_rdata, idle_unasg_count, u_data;
    logic         u_clk, u_prty, u_soc, u_enb_n, cell_valid, parity_err, loopback_en, rx_width8;
    logic [4:0]   u_addr;
    cell_result_t cell_out;
    int           mismatches = 0, checks = 0, exp_cnt = 0;
    utopia_in_ctrl utopia_in_ctrl_i (.core_clk(core_clk), .resetn(resetn), .cpu_cs(cpu_cs),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .u_clk(u_clk), .u_data(u_data), .u_prty(u_prty),
        .u_soc(u_soc), .u_enb_n(u_enb_n), .u_addr(u_addr), .cell_out(cell_out),
        .cell_valid(cell_valid), .parity_err(parity_err), .loopback_en(loopback_en),
        .idle_unasg_count(idle_unasg_count), .rx_width8(rx_width8));
    atm_master_model atm_master_model_i (.u_clk(u_clk), .u_data(u_data), .u_prty(u_prty),
        .u_soc(u_soc), .u_enb_n(u_enb_n), .u_addr(u_addr));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    function automatic logic [7:0] hec_of(input logic [31:0] h, input logic plain);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? HEC_POLY : 8'h00);
        return plain ? c : c ^ HEC_COSET;
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // request stays up after the call; the next call changes it one cycle later
    task automatic op(input logic w, input logic r, input logic [7:0] a,
                      input logic [15:0] d);
        @(negedge core_clk);
        cpu_cs = w | r;
        cpu_wr = w;
        cpu_rd = r;
        cpu_addr = a;
        cpu_wdata = d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        op(1'b1, 1'b0, a, d);
        op(1'b0, 1'b0, 8'h00, 16'h0000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        op(1'b0, 1'b1, a, 16'h0000);
        op(1'b0, 1'b0, 8'h00, 16'h0000);
        @(negedge core_clk);
        `CHK(cpu_rdata, e)
    endtask
    // write the request, then read on the two following edges
    task automatic snap(input logic [15:0] e);
        op(1'b1, 1'b0, OFF_PERR, 16'h2000);
        repeat (2) op(1'b0, 1'b1, OFF_PERR, 16'h0000);
        op(1'b0, 1'b0, 8'h00, 16'h0000);
        @(negedge core_clk);
        `CHK(cpu_rdata, e)
    endtask
    task automatic run_cell(input logic [4:0] a, input logic [39:0] h, input logic w8,
                            input logic even, input logic bad, input logic want);
        seen = 1'b0;
        fork
            atm_master_model_i.send(a, h, w8, even, bad);
            for (int n = 0; n < 200 && !seen; n++) begin
                @(negedge core_clk);
                seen = cell_valid;
            end
        join
        `CHK(seen, want)
        if (want && !seen)
            print_verdict();
    endtask
    initial begin
        resetn = 1'b0;
        {cpu_cs, cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = '0;
        repeat (6) @(negedge core_clk);
        resetn = 1'b1;
        wr(OFF_LINK_EN, 16'h0101);
        wr(OFF_ADDR_BASE, 16'h0905);
        foreach (rows[i]) begin
            wr(OFF_CTRL, rows[i].ctl);
            run_cell(5'h05, {rows[i].hdr, hec_of(rows[i].hdr, rows[i].ctl[2])} ^ rows[i].flip,
                     rows[i].ctl[7], rows[i].ctl[12], 1'b0, 1'b1);
            fdrop = (rows[i].hdr == 32'h1 && rows[i].ctl[3]) ||
                    (rows[i].hdr[31:4] == 28'h0 && !rows[i].hdr[0] && rows[i].ctl[4]);
            exp_cnt += int'(fdrop);
            `CHK(cell_out.header, rows[i].corr ? rows[i].hdr : rows[i].hdr ^ rows[i].flip[39:8])
            `CHK(cell_out.drop, rows[i].drop)
            `CHK(cell_out.corrected, rows[i].corr)
            `CHK(cell_out.link, 4'h0)
            `CHK(cell_out.idle_unasg, fdrop)
            repeat (3) @(negedge core_clk);
            `CHK(idle_unasg_count, exp_cnt[15:0])
            `CHK(rx_width8, rows[i].ctl[7])
        end
        wr(OFF_CTRL, 16'hFFFF);
        rd(OFF_CTRL, 16'h1FFF);
        `CHK(loopback_en, 1'b1)
        run_cell(5'h05, {USR, hec_of(USR, 1'b1)}, 1'b1, 1'b1, 1'b0, 1'b0);
        wr(OFF_CTRL, 16'h0000);
        wr(OFF_ADDR_BASE + 8'h01, 16'hFFFF);
        rd(OFF_ADDR_BASE + 8'h01, 16'h1F1F);
        rd(OFF_LINK_EN, 16'h0101);
        wr(8'h60, 16'hFFFF);
        rd(8'h60, 16'h0000);
        run_cell(5'h09, {USR, hec_of(USR, 1'b0)}, 1'b0, 1'b0, 1'b0, 1'b1);
        `CHK(cell_out.link, 4'h8)
        run_cell(5'h06, {USR, hec_of(USR, 1'b0)}, 1'b0, 1'b0, 1'b0, 1'b0);
        // hold a status read so the flag is watched while errors arrive
        op(1'b0, 1'b1, OFF_PERR, 16'h0000);
        run_cell(5'h05, {USR, hec_of(USR, 1'b0)}, 1'b0, 1'b0, 1'b1, 1'b1);
        op(1'b0, 1'b0, 8'h00, 16'h0000);
        snap(16'h2003);
        run_cell(5'h05, {USR, hec_of(USR, 1'b0)}, 1'b0, 1'b0, 1'b1, 1'b1);
        rd(OFF_PERR, 16'h6003);
        wr(OFF_PERR, 16'h0000);
        rd(OFF_PERR, 16'h2003);
        wr(OFF_PERR, 16'h1000);
        rd(OFF_PERR, 16'h3003);
        snap(16'h2000);
        @(negedge core_clk);
        resetn = 1'b0;
        repeat (3) @(negedge core_clk);
        resetn = 1'b1;
        rd(OFF_LINK_EN, RST_LINK_EN);
        rd(OFF_CTRL, RST_CTRL);
        rd(OFF_PERR, 16'h0000);
        rd(OFF_ADDR_BASE, RST_ADDR);
        print_verdict();
    end
endmodule // utopia_in_ctrl_bench
bind utopia_in_ctrl utopia_in_ctrl_props utopia_in_ctrl_props_i (.core_clk(core_clk),
    .resetn(resetn), .cpu_cs(cpu_cs), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cell_out(cell_out), .cell_valid(cell_valid), .parity_err(parity_err),
    .loopback_en(loopback_en), .rx_width8(rx_width8));
`default_nettype wire

// [testbench/utopia_in_ctrl_props.sv]
`timescale 1ns/1ps
`default_nettype none
module utopia_in_ctrl_props (
    // clock and reset
    input wire logic                        core_clk,
    input wire logic                        resetn,
    // register port
    input wire logic                        cpu_cs,
    input wire logic                        cpu_wr,
    input wire logic                        cpu_rd,
    input wire logic [7:0]                  cpu_addr,
    input wire logic [15:0]                 cpu_wdata,
    input wire logic [15:0]                 cpu_rdata,
    // results
    input wire utopia_in_pkg::cell_result_t cell_out,
    input wire logic                        cell_valid,
    input wire logic                        parity_err,
    input wire logic                        loopback_en,
    input wire logic                        rx_width8
);
    import utopia_in_pkg::*;
    wire wr_ctrl = cpu_cs && cpu_wr && cpu_addr == OFF_CTRL;
    wire rd_ctrl = cpu_cs && cpu_rd && cpu_addr == OFF_CTRL;
    wire wr_perr = cpu_cs && cpu_wr && cpu_addr == OFF_PERR;
    wire rd_perr = cpu_cs && cpu_rd && cpu_addr == OFF_PERR;
    // shadow of control writes; the checker cannot see the register itself
    logic [15:0] ctrl_r;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            ctrl_r <= RST_CTRL;
        else if (wr_ctrl)
            ctrl_r <= cpu_wdata;
    end
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_snap;
        wr_perr && cpu_wdata[PERR_XFER];
    endsequence
    sequence s_perr_rd;
        rd_perr && !wr_perr;
    endsequence
    AST_LOOP: assert property (wr_ctrl |=> loopback_en == $past(cpu_wdata[CTRL_LOOPBACK]))
        else $error("loopback output differs from written bit");
    AST_WIDTH: assert property (wr_ctrl |=> rx_width8 == $past(cpu_wdata[CTRL_WIDTH8]))
        else $error("width output differs from written bit");
    AST_TOP_ZERO: assert property (rd_ctrl |=> cpu_rdata[15:14] == 2'b00)
        else $error("control top bits read nonzero");
    AST_XFER_WAIT: assert property (s_snap ##1 s_perr_rd |=> !cpu_rdata[PERR_XFER])
        else $error("snapshot done too early");
    AST_XFER_DONE: assert property (s_snap ##1 !wr_perr ##1 s_perr_rd |=> cpu_rdata[PERR_XFER])
        else $error("snapshot not done after two cycles");
    AST_SEEN_SET: assert property (parity_err ##1 s_perr_rd |=> cpu_rdata[PERR_SEEN])
        else $error("error seen flag not set");
    AST_HOLD_RST: assert property (ctrl_r[CTRL_CTL_RESET] [*8] |-> !cell_valid && !parity_err)
        else $error("activity while controller held in reset");
    AST_IDLE_DROP: assert property (cell_valid && ctrl_r[CTRL_IDLE_FILT]
        && cell_out.header == 32'h00000001 |-> cell_out.drop)
        else $error("idle cell not dropped");
    AST_UNASG_DROP: assert property (cell_valid && ctrl_r[CTRL_UNASG_FILT]
        && cell_out.header[31:4] == 28'h0 && !cell_out.header[0] |-> cell_out.drop)
        else $error("unassigned cell not dropped");
endmodule // utopia_in_ctrl_props
`default_nettype wire
